// >>> logic/sdw_frame_check.sv
/*
 * Frame length checker: flags a transfer whose clock pulse count is not
 * whole bytes or is shorter than the minimum frame.
 * Assumes frame_end_i is a one-cycle pulse with the count valid beside it.
 */
`timescale 1ns/1ps
module sdw_frame_check (
   // Clock and reset.
   input  wire logic                            clk_sys_i,
   input  wire logic                            rst_n_i,
   // Frame end and pulse count.
   input  wire logic                            frame_end_i,
   input  wire logic [sdw_pkg::FRAME_CNT_W-1:0] frame_bits_i,
   // One-cycle error pulse.
   output logic                                 frame_error_o
);
   import sdw_pkg::*;

   wire logic not_bytes;
   wire logic too_short;
   wire logic bad_frame;
   logic      err_reg;

   assign not_bytes = (frame_bits_i[$bits(BYTE_REM_ZERO)-1:0] != BYTE_REM_ZERO);
   assign too_short = (frame_bits_i < FRAME_MIN_BITS);
   assign bad_frame = frame_end_i & (not_bytes | too_short);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_reg <= LATCH_RESET;
      end else begin
         err_reg <= bad_frame;
      end
   end

   assign frame_error_o = err_reg;

endmodule : sdw_frame_check

// >>> logic/sdw_pkg.sv
/*
 * Constants for the standard diagnosis word: bit positions, state codes,
 * reset values and frame length checks.
 * Assumes a single logic clock and an active-low undervoltage reset.
 */
package sdw_pkg;

   localparam int unsigned STD_W       = 16;
   localparam int unsigned NUM_CH      = 2;
   localparam int unsigned FRAME_CNT_W = 8;

   // Bit positions in the standard diagnosis word.
   localparam int unsigned BIT_ANSWER_KIND = 15;
   localparam int unsigned BIT_SOFT_RST    = 14;
   localparam int unsigned BIT_SUPPLY_UV   = 13;
   localparam int unsigned BIT_STATE_HI    = 12;
   localparam int unsigned BIT_STATE_LO    = 11;
   localparam int unsigned BIT_FRAME_ERR   = 10;
   localparam int unsigned BIT_MON_DONE    = 9;
   localparam int unsigned BIT_UNUSED      = 8;
   localparam int unsigned BIT_CAL_DONE    = 7;
   localparam int unsigned BIT_BOOT_CH2    = 6;
   localparam int unsigned BIT_BOOT_CH1    = 5;
   localparam int unsigned BIT_DRV_LOW     = 4;
   localparam int unsigned BIT_LOAD_B      = 3;
   localparam int unsigned BIT_LOAD_A      = 2;
   localparam int unsigned BIT_SHUTDOWN    = 1;
   localparam int unsigned BIT_WARN        = 0;

   // Operating state codes.
   localparam logic [1:0] STATE_RSVD   = 2'h0;
   localparam logic [1:0] STATE_LIMP   = 2'h1;
   localparam logic [1:0] STATE_ACTIVE = 2'h2;
   localparam logic [1:0] STATE_IDLE   = 2'h3;

   localparam logic        ANSWER_KIND_DIAG = 1'h0;
   localparam logic        UNUSED_VALUE     = 1'h0;
   localparam logic [15:0] STD_NOMINAL      = 16'h1000;

   // Reset values; the supply flag reports the undervoltage reset itself.
   localparam logic        SUPPLY_UV_RESET  = 1'h1;
   localparam logic        LATCH_RESET      = 1'h0;
   localparam logic        SEL_CH1          = 1'h0;
   localparam logic        SEL_CH2          = 1'h1;
   localparam logic [15:0] STD_RESET        = 16'h0000;

   // Frame length check: whole bytes, at least this many clock pulses.
   localparam logic [FRAME_CNT_W-1:0] FRAME_MIN_BITS = 8'h10;
   localparam logic [2:0]             BYTE_REM_ZERO  = 3'h0;

endpackage : sdw_pkg

// >>> logic/sdw_std_diag.sv
/*
 * Standard diagnosis word assembly: latched events cleared on readout,
 * thermal and overvoltage latches cleared by the clear-latches command,
 * live state flags, mirrors of calibration and monitor completion, and
 * per-channel fault summaries. Index 0 of channel vectors is channel 1.
 * Assumes event inputs are synchronous to clk_sys_i and read_std_i pulses
 * in the cycle the word is taken for shifting out.
 */
`timescale 1ns/1ps
module sdw_std_diag (
   // Clock and reset.
   input  wire logic                            clk_sys_i,
   input  wire logic                            rst_n_i,
   // Readout and commands.
   input  wire logic                            read_std_i,
   input  wire logic                            clear_latches_i,
   input  wire logic                            soft_reset_i,
   // Frame check.
   input  wire logic                            frame_end_i,
   input  wire logic [sdw_pkg::FRAME_CNT_W-1:0] frame_bits_i,
   // Supply and thermal events.
   input  wire logic                            supply_undervolt_i,
   input  wire logic                            driver_supply_low_i,
   input  wire logic                            thermal_shutdown_i,
   input  wire logic                            thermal_warning_i,
   // Operating state.
   input  wire logic                            limp_home_i,
   input  wire logic                            idle_i,
   // Per-channel flags.
   input  wire logic [sdw_pkg::NUM_CH-1:0]      boot_cap_low_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      led_short_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      open_load_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      output_overvolt_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      monitor_start_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      monitor_done_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      calib_start_i,
   input  wire logic [sdw_pkg::NUM_CH-1:0]      calib_done_i,
   // Word and switching control.
   output logic [sdw_pkg::STD_W-1:0]            standard_diagnosis_o,
   output logic [sdw_pkg::NUM_CH-1:0]           switch_halt_o
);
   import sdw_pkg::*;

   logic                soft_reset_seen_reg;
   logic                supply_undervolt_seen_reg;
   logic                frame_error_reg;
   logic                driver_supply_low_reg;
   logic                thermal_shutdown_reg;
   logic [NUM_CH-1:0]   boot_cap_low_reg;
   logic [NUM_CH-1:0]   output_overvolt_reg;
   logic [NUM_CH-1:0]   switch_halt_reg;
   logic                mon_sel_reg;
   logic                cal_sel_reg;
   logic [STD_W-1:0]    std_reg;

   wire logic              soft_reset_seen_next;
   wire logic              supply_undervolt_seen_next;
   wire logic              frame_error_next;
   wire logic              driver_supply_low_next;
   wire logic              thermal_shutdown_next;
   wire logic [NUM_CH-1:0] boot_cap_low_next;
   wire logic [NUM_CH-1:0] output_overvolt_next;
   wire logic [NUM_CH-1:0] switch_halt_next;
   wire logic [NUM_CH-1:0] load_fault;
   wire logic              mon_sel_next;
   wire logic              cal_sel_next;
   wire logic [1:0]        state_code;
   wire logic [STD_W-1:0]  std_next;
   wire logic              frame_error_pulse;

   sdw_frame_check u_frame_check (
      .clk_sys_i     (clk_sys_i),
      .rst_n_i       (rst_n_i),
      .frame_end_i   (frame_end_i),
      .frame_bits_i  (frame_bits_i),
      .frame_error_o (frame_error_pulse)
   );

   // Readout clears, and the clear-latches command clears thermal shutdown; a new event in the same cycle wins.
   assign soft_reset_seen_next = soft_reset_i |
                                 (soft_reset_seen_reg & ~read_std_i);
   assign supply_undervolt_seen_next = supply_undervolt_i |
                                       (supply_undervolt_seen_reg & ~read_std_i);
   assign frame_error_next = frame_error_pulse |
                             (frame_error_reg & ~read_std_i);
   assign driver_supply_low_next = driver_supply_low_i |
                                   (driver_supply_low_reg & ~read_std_i);
   assign thermal_shutdown_next = thermal_shutdown_i |
                                  (thermal_shutdown_reg & ~clear_latches_i);

   // Mirror source follows the last start command; channel 2 wins a tie.
   assign mon_sel_next = monitor_start_i[1] ? SEL_CH2 :
                         monitor_start_i[0] ? SEL_CH1 : mon_sel_reg;
   assign cal_sel_next = calib_start_i[1] ? SEL_CH2 :
                         calib_start_i[0] ? SEL_CH1 : cal_sel_reg;

   // Limp home overrides idle; otherwise the device is active.
   assign state_code = limp_home_i ? STATE_LIMP :
                       idle_i      ? STATE_IDLE : STATE_ACTIVE;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         assign boot_cap_low_next[ch] = boot_cap_low_i[ch] |
                                        (boot_cap_low_reg[ch] & ~read_std_i);
         assign output_overvolt_next[ch] = output_overvolt_i[ch] |
                                           (output_overvolt_reg[ch] & ~clear_latches_i);
         assign switch_halt_next[ch] = output_overvolt_next[ch] |
                                       thermal_shutdown_next;
         assign load_fault[ch] = led_short_i[ch] | open_load_i[ch] |
                                 output_overvolt_next[ch];
      end
   endgenerate

   // Nominal fault-free active readout equals STD_NOMINAL.
   assign std_next[BIT_ANSWER_KIND] = ANSWER_KIND_DIAG;
   assign std_next[BIT_SOFT_RST]    = soft_reset_seen_next;
   assign std_next[BIT_SUPPLY_UV]   = supply_undervolt_seen_next;
   assign std_next[BIT_STATE_HI:BIT_STATE_LO] = state_code;
   assign std_next[BIT_FRAME_ERR]   = frame_error_next;
   assign std_next[BIT_MON_DONE]    = monitor_done_i[mon_sel_next];
   assign std_next[BIT_UNUSED]      = UNUSED_VALUE;
   assign std_next[BIT_CAL_DONE]    = calib_done_i[cal_sel_next];
   assign std_next[BIT_BOOT_CH2]    = boot_cap_low_next[1];
   assign std_next[BIT_BOOT_CH1]    = boot_cap_low_next[0];
   assign std_next[BIT_DRV_LOW]     = driver_supply_low_next;
   assign std_next[BIT_LOAD_B]      = load_fault[1];
   assign std_next[BIT_LOAD_A]      = load_fault[0];
   assign std_next[BIT_SHUTDOWN]    = thermal_shutdown_next;
   assign std_next[BIT_WARN]        = thermal_warning_i;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_reset_seen_reg       <= LATCH_RESET;
         supply_undervolt_seen_reg <= SUPPLY_UV_RESET;
         frame_error_reg           <= LATCH_RESET;
         driver_supply_low_reg     <= LATCH_RESET;
         thermal_shutdown_reg      <= LATCH_RESET;
         boot_cap_low_reg          <= {NUM_CH{LATCH_RESET}};
         output_overvolt_reg       <= {NUM_CH{LATCH_RESET}};
         switch_halt_reg           <= {NUM_CH{LATCH_RESET}};
         mon_sel_reg               <= SEL_CH1;
         cal_sel_reg               <= SEL_CH1;
         std_reg                   <= STD_RESET;
      end else begin
         soft_reset_seen_reg       <= soft_reset_seen_next;
         supply_undervolt_seen_reg <= supply_undervolt_seen_next;
         frame_error_reg           <= frame_error_next;
         driver_supply_low_reg     <= driver_supply_low_next;
         thermal_shutdown_reg      <= thermal_shutdown_next;
         boot_cap_low_reg          <= boot_cap_low_next;
         output_overvolt_reg       <= output_overvolt_next;
         switch_halt_reg           <= switch_halt_next;
         mon_sel_reg               <= mon_sel_next;
         cal_sel_reg               <= cal_sel_next;
         std_reg                   <= std_next;
      end
   end

   assign standard_diagnosis_o = std_reg;
   assign switch_halt_o        = switch_halt_reg;

   a_soft_rst_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      soft_reset_i |=> standard_diagnosis_o[BIT_SOFT_RST])
      else $error("Soft reset event not reported.");

   a_soft_rst_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      read_std_i && !soft_reset_i |=> !standard_diagnosis_o[BIT_SOFT_RST])
      else $error("Soft reset flag not cleared by readout.");

   a_uv_read_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      read_std_i && !supply_undervolt_i |=> !standard_diagnosis_o[BIT_SUPPLY_UV])
      else $error("Supply undervoltage flag not cleared by readout.");

   a_shutdown_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      standard_diagnosis_o[BIT_SHUTDOWN] && !clear_latches_i
      |=> standard_diagnosis_o[BIT_SHUTDOWN])
      else $error("Thermal shutdown latch dropped without clear command.");

   a_clear_restarts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      clear_latches_i && !thermal_shutdown_i && (output_overvolt_i == '0)
      |=> !standard_diagnosis_o[BIT_SHUTDOWN] && (switch_halt_o == '0))
      else $error("Clear command did not release latches and switching.");

   a_halt_on_ovv: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      output_overvolt_i[0] |=> switch_halt_o[0] && standard_diagnosis_o[BIT_LOAD_A])
      else $error("Channel 1 overvoltage did not halt switching.");

   a_state_limp: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      limp_home_i |=> standard_diagnosis_o[BIT_STATE_HI:BIT_STATE_LO] == STATE_LIMP)
      else $error("Limp home state code wrong.");

   a_warn_live: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !thermal_warning_i |=> !standard_diagnosis_o[BIT_WARN])
      else $error("Thermal warning held after condition ended.");

   a_fixed_zeros: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !standard_diagnosis_o[BIT_ANSWER_KIND] && !standard_diagnosis_o[BIT_UNUSED])
      else $error("Fixed zero bits of diagnosis word set.");

   a_frame_err: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      frame_end_i && (frame_bits_i < FRAME_MIN_BITS) |-> ##2 standard_diagnosis_o[BIT_FRAME_ERR])
      else $error("Short frame not reported as error.");

   a_load_b_short: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      led_short_i[1] |=> standard_diagnosis_o[BIT_LOAD_B])
      else $error("Channel 2 fault summary missed a shorted LED.");

   a_mon_mirror: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      monitor_start_i == 2'h2 ##1 monitor_start_i == 2'h0
      |=> standard_diagnosis_o[BIT_MON_DONE] == $past(monitor_done_i[1]))
      else $error("Monitor done not mirrored from channel 2.");

   a_nominal_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      read_std_i && !limp_home_i && !idle_i && !thermal_warning_i && !frame_error_pulse &&
      !soft_reset_i && !supply_undervolt_i && !driver_supply_low_i && !thermal_shutdown_i &&
      !thermal_shutdown_reg && (output_overvolt_reg == '0) && (output_overvolt_i == '0) &&
      ((boot_cap_low_i | led_short_i | open_load_i | monitor_done_i | calib_done_i) == '0)
      |=> standard_diagnosis_o == STD_NOMINAL)
      else $error("Fault-free active word not nominal.");

endmodule : sdw_std_diag

// >>> tb/sdw_spi_master.sv
/*
 * Model of the SPI master: ends a frame of a chosen length and takes the word.
 * Assumes the block samples the read and frame strobes on clk_sys_i.
 */
`timescale 1ns/1ps
module sdw_spi_master (
   // Clock.
   input  wire logic                            clk_sys_i,
   // Word from the block.
   input  wire logic [sdw_pkg::STD_W-1:0]       word_i,
   // Frame end and readout strobes.
   output logic                                 read_std_o,
   output logic                                 frame_end_o,
   output logic [sdw_pkg::FRAME_CNT_W-1:0]      frame_bits_o
);
   import sdw_pkg::*;
   initial begin
      read_std_o   = 1'b0;
      frame_end_o  = 1'b0;
      frame_bits_o = 8'h10;
   end
   // Ends one frame and returns the word shifted out during it.
   task automatic frame(input logic [7:0] bits, output logic [15:0] w);
      @(posedge clk_sys_i);
      read_std_o   <= 1'b1;
      frame_end_o  <= 1'b1;
      frame_bits_o <= bits;
      #1 w = word_i;
      @(posedge clk_sys_i);
      read_std_o   <= 1'b0;
      frame_end_o  <= 1'b0;
   endtask : frame
endmodule : sdw_spi_master

// >>> tb/sdw_std_diag_test.sv
/*
 * Self-checking bench for the standard diagnosis word.
 * Assumes the SPI master model drives the readout and frame strobes.
 */
`timescale 1ns/1ps
module sdw_std_diag_test;
   import sdw_pkg::*;
   logic        clk_sys_i, rst_n_i, clear_latches_i, soft_reset_i, supply_undervolt_i;
   logic        driver_supply_low_i, thermal_shutdown_i, thermal_warning_i, limp_home_i;
   logic        idle_i, read_std_i, frame_end_i;
   logic [1:0]  boot_cap_low_i, led_short_i, open_load_i, output_overvolt_i;
   logic [1:0]  monitor_start_i, monitor_done_i, calib_start_i, calib_done_i, switch_halt_o;
   logic [7:0]  frame_bits_i;
   logic [15:0] standard_diagnosis_o, w;
   int          fails, total_checks;

   sdw_std_diag u_dut (.clk_sys_i, .rst_n_i, .read_std_i, .clear_latches_i, .soft_reset_i,
      .frame_end_i, .frame_bits_i, .supply_undervolt_i, .driver_supply_low_i,
      .thermal_shutdown_i, .thermal_warning_i, .limp_home_i, .idle_i, .boot_cap_low_i,
      .led_short_i, .open_load_i, .output_overvolt_i, .monitor_start_i, .monitor_done_i,
      .calib_start_i, .calib_done_i, .standard_diagnosis_o, .switch_halt_o);
   sdw_spi_master u_master (.clk_sys_i, .word_i(standard_diagnosis_o),
      .read_std_o(read_std_i), .frame_end_o(frame_end_i), .frame_bits_o(frame_bits_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic rd(input logic [7:0] bits, input logic [15:0] exp, input string what);
      @(posedge clk_sys_i);
      u_master.frame(bits, w);
      check(what, w, exp);
   endtask : rd
   task automatic clr();
      @(posedge clk_sys_i);
      clear_latches_i <= 1'b1;
      @(posedge clk_sys_i);
      clear_latches_i <= 1'b0;
   endtask : clr
   task automatic test_done();
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   task automatic t_events();
      @(posedge clk_sys_i);
      soft_reset_i        <= 1'b1;
      supply_undervolt_i  <= 1'b1;
      driver_supply_low_i <= 1'b1;
      @(posedge clk_sys_i);
      soft_reset_i        <= 1'b0;
      supply_undervolt_i  <= 1'b0;
      driver_supply_low_i <= 1'b0;
      rd(8'h10, 16'h7010, "event word");
      rd(8'h10, 16'h1000, "events cleared");
      for (int c = 0; c < 2; c++) begin
         @(posedge clk_sys_i);
         boot_cap_low_i <= 2'h1 << c;
         @(posedge clk_sys_i);
         boot_cap_low_i <= 2'h0;
         rd(8'h10, 16'h1000 | (16'h0020 << c), "boot cap");
      end
      rd(8'h10, 16'h1000, "boot cleared");
   endtask : t_events
   task automatic t_frame();
      logic [7:0]  lens [4] = '{8'h0c, 8'h08, 8'h18, 8'h11};
      logic [15:0] exps [4] = '{16'h1400, 16'h1400, 16'h1000, 16'h1400};
      for (int i = 0; i < 4; i++) begin
         u_master.frame(lens[i], w);
         rd(8'h10, exps[i], "frame error");
      end
   endtask : t_frame
   task automatic t_state();
      logic [15:0] exps [4] = '{16'h1000, 16'h1801, 16'h0800, 16'h0801};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         limp_home_i       <= i[1];
         idle_i            <= i[0];
         thermal_warning_i <= i[0];
         rd(8'h10, exps[i], "state");
      end
      @(posedge clk_sys_i);
      limp_home_i       <= 1'b0;
      idle_i            <= 1'b0;
      thermal_warning_i <= 1'b0;
   endtask : t_state
   task automatic t_thermal();
      @(posedge clk_sys_i);
      thermal_shutdown_i <= 1'b1;
      @(posedge clk_sys_i);
      thermal_shutdown_i <= 1'b0;
      rd(8'h10, 16'h1002, "shutdown");
      check("halt", {14'h0, switch_halt_o}, 16'h0003);
      rd(8'h10, 16'h1002, "shutdown held");
      clr();
      rd(8'h10, 16'h1000, "shutdown cleared");
      check("halt", {14'h0, switch_halt_o}, 16'h0000);
   endtask : t_thermal
   task automatic t_faults();
      @(posedge clk_sys_i);
      led_short_i <= 2'h2;
      rd(8'h10, 16'h1008, "fault b");
      @(posedge clk_sys_i);
      led_short_i <= 2'h0;
      open_load_i <= 2'h1;
      rd(8'h10, 16'h1004, "fault a");
      @(posedge clk_sys_i);
      open_load_i       <= 2'h0;
      output_overvolt_i <= 2'h1;
      @(posedge clk_sys_i);
      output_overvolt_i <= 2'h0;
      rd(8'h10, 16'h1004, "overvolt a");
      check("halt", {14'h0, switch_halt_o}, 16'h0001);
      @(posedge clk_sys_i);
      output_overvolt_i <= 2'h2;
      @(posedge clk_sys_i);
      output_overvolt_i <= 2'h0;
      rd(8'h10, 16'h100c, "overvolt");
      check("halt", {14'h0, switch_halt_o}, 16'h0003);
      clr();
      rd(8'h10, 16'h1000, "overvolt cleared");
      check("halt", {14'h0, switch_halt_o}, 16'h0000);
   endtask : t_faults
   task automatic t_mirrors();
      @(posedge clk_sys_i);
      calib_done_i    <= 2'h2;
      monitor_done_i  <= 2'h1;
      calib_start_i   <= 2'h2;
      monitor_start_i <= 2'h1;
      @(posedge clk_sys_i);
      calib_start_i   <= 2'h1;
      monitor_start_i <= 2'h2;
      @(posedge clk_sys_i);
      calib_start_i   <= 2'h0;
      monitor_start_i <= 2'h0;
      rd(8'h10, 16'h1000, "mirror select");
      @(posedge clk_sys_i);
      calib_done_i   <= 2'h1;
      monitor_done_i <= 2'h2;
      rd(8'h10, 16'h1280, "mirror follow");
   endtask : t_mirrors

   initial begin
      {rst_n_i, clear_latches_i, soft_reset_i, supply_undervolt_i, driver_supply_low_i} = '0;
      {thermal_shutdown_i, thermal_warning_i, limp_home_i, idle_i} = '0;
      {boot_cap_low_i, led_short_i, open_load_i, output_overvolt_i} = '0;
      {monitor_start_i, monitor_done_i, calib_start_i, calib_done_i} = '0;
      fails        = 0;
      total_checks = 0;
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(8'h10, 16'h3000, "first word");
      rd(8'h10, 16'h1000, "nominal word");
      t_events();
      t_frame();
      t_state();
      t_thermal();
      t_faults();
      t_mirrors();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      test_done();
   end
endmodule : sdw_std_diag_test
